// ---- core/ccr_top.sv ----
// clock generation unit control registers: pll codes, low-power divider, lock pin, converter clock
`timescale 1ns/100ps

// Functional notes
// - input divide ratio is the five-bit input code plus one.
// - output divide ratio is two raised to the two-bit output code.
// - pll output is input times feedback ratio over input and output ratios.
// - system clock is pll output over two to the low-power code, next edge.
// - changing the low-power code never disturbs pll lock.
// - lock select one drives lock indication on pin, zero gives gpio g bit 0.
// - enable one selects pll clock, zero selects external clock directly.
// - enable zero powers the pll oscillator down outside stop mode.
// - enable bit may change at any time without timing restriction.
// - stop-keep zero powers pll down in stop; one keeps it powered up, whatever the enable.
// - clock gate bit 0 switches converter clock, resets to one.
// - gate, pll control and divider registers at 0xffff7c, 7d, 7e.
// - pll control resets to 0x2b60c2 with strap high, enable zero otherwise.
// - converter divider holds seven-bit factor, resets to 0x22.
// - strap loads the enable bit at reset, ignored afterwards.
// - converter enable divides by factor plus one.
module ccr_top (
   // clock and reset
   input  wire logic                          core_clk,
   input  wire logic                          rst_n,
   // register port
   input  wire logic [ccr_pkg::ADDR_W-1:0]    bus_addr,
   input  wire logic                          bus_wr,
   input  wire logic                          bus_rd,
   input  wire logic [ccr_pkg::DATA_W-1:0]    bus_wdata,
   output var  logic [ccr_pkg::DATA_W-1:0]    bus_rdata,
   output var  logic                          bus_rvalid,
   // straps and system state
   input  wire logic                          pll_boot_strap,
   input  wire logic                          stop_mode,
   // analog pll macro
   output var  logic [ccr_pkg::IDIV_W-1:0]    input_divide_ratio_code,
   output var  logic [ccr_pkg::FB_W-1:0]      feedback_ratio_code,
   output var  logic [ccr_pkg::ODIV_W-1:0]    output_div_sel,
   output var  logic                          pll_powerdown,
   output var  logic                          pll_bypass,
   input  wire logic                          lock_indicator,
   // effective ratios for consumers and observation
   output var  logic [ccr_pkg::IDIV_W:0]      input_divide_ratio,
   output var  logic [ccr_pkg::FB_W:0]        feedback_ratio,
   output var  logic [7:0]                    output_div_ratio,
   // clock selection and low-power divider
   output var  logic                          clk_src_pll,
   output var  logic [ccr_pkg::LPDIV_W-1:0]   lowpower_div_sel,
   output var  logic                          sys_clk_en,
   // shared lock / gpio pin
   input  wire logic                          lock_pin_i,
   output var  logic                          lock_pin_o,
   output var  logic                          lock_pin_oe,
   input  wire logic                          gpio_g_bit0_o,
   input  wire logic                          gpio_g_bit0_oe,
   output var  logic                          gpio_g_bit0_i,
   // rate converter clock
   output var  logic                          src_clock_on,
   output var  logic [ccr_pkg::SRC_DIV_W-1:0] src_div_factor,
   output var  logic                          src_clk_en
);

   localparam int NS = ccr_pkg::SYNC_STAGES;
   localparam int BC = $clog2(ccr_pkg::STRAP_SETTLE_CYC);
   localparam logic [BC-1:0] BOOT_LAST = BC'(ccr_pkg::STRAP_SETTLE_CYC - 1);
   localparam logic [ccr_pkg::DATA_W-1:0] RST_PLL_NOSTRAP =
      ccr_pkg::RST_PLL_CTRL & ~ccr_pkg::MASK_PLL_EN;

   // input index in the synchroniser bank
   localparam int IX_STRAP = 0;
   localparam int IX_LOCK  = 1;
   localparam int IX_PIN   = 2;

   // one-hot power of two for a three-bit exponent
   function automatic logic [7:0] ccr_pow2(input logic [2:0] e);
      ccr_pow2 = 8'h01 << e;
   endfunction

   ccr_clk_if cif ();

   // ------------------------------------------------------------------
   // input synchronisers: three stages, value taken when stages 2 and 3 agree
   logic [NS-1:0] raw_in;
   logic [NS-1:0] sy1_q, sy2_q, sy3_q;
   logic [NS-1:0] flt_q, flt_d;

   assign raw_in[IX_STRAP] = pll_boot_strap;
   assign raw_in[IX_LOCK]  = lock_indicator;
   assign raw_in[IX_PIN]   = lock_pin_i;

   generate
      for (genvar i = 0; i < NS; i++) begin : g_flt
         always_comb begin
            flt_d[i] = (sy2_q[i] == sy3_q[i]) ? sy3_q[i] : flt_q[i];
         end
      end
   endgenerate

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sy1_q <= '0;
         sy2_q <= '0;
         sy3_q <= '0;
         flt_q <= '0;
      end else begin
         sy1_q <= raw_in;
         sy2_q <= sy1_q;
         sy3_q <= sy2_q;
         flt_q <= flt_d;
      end
   end

   // ------------------------------------------------------------------
   // register file
   logic [ccr_pkg::DATA_W-1:0] clk_gate_q, clk_gate_d;
   logic [ccr_pkg::DATA_W-1:0] pll_ctrl_q, pll_ctrl_d;
   logic [ccr_pkg::DATA_W-1:0] src_div_q, src_div_d;
   logic [ccr_pkg::DATA_W-1:0] rdata_q, rdata_d;
   logic                       rvalid_q, rvalid_d;
   ccr_pkg::ccr_boot_t         boot_q, boot_d;
   logic [BC-1:0]              boot_cnt_q, boot_cnt_d;
   logic                       sw_wrote_q, sw_wrote_d;
   logic                       wr_gate, wr_pll, wr_src;
   logic [ccr_pkg::DATA_W-1:0] wval;

   assign wr_gate = bus_wr && (bus_addr == ccr_pkg::ADDR_CLK_GATE);
   assign wr_pll  = bus_wr && (bus_addr == ccr_pkg::ADDR_PLL_CTRL);
   assign wr_src  = bus_wr && (bus_addr == ccr_pkg::ADDR_SRC_DIV);
   // reserved bits are dropped so they always read back as zero
   assign wval    = bus_wdata & ccr_pkg::WMASK_PLL_CTRL;

   always_comb begin
      clk_gate_d = clk_gate_q;
      pll_ctrl_d = pll_ctrl_q;
      src_div_d  = src_div_q;
      boot_d     = boot_q;
      boot_cnt_d = boot_cnt_q;
      sw_wrote_d = sw_wrote_q;
      if (wr_gate) begin
         clk_gate_d = bus_wdata & ccr_pkg::WMASK_CLK_GATE;
      end
      if (wr_src) begin
         src_div_d = bus_wdata & ccr_pkg::WMASK_SRC_DIV;
      end
      // enable may be rewritten at any moment; nothing blocks it
      if (wr_pll) begin
         pll_ctrl_d = wval;
         sw_wrote_d = 1'b1;
      end
      case (boot_q)
         ccr_pkg::CCR_BOOT_SETTLE: begin
            boot_cnt_d = boot_cnt_q + BC'(1);
            if (boot_cnt_q == BOOT_LAST) begin
               boot_d = ccr_pkg::CCR_BOOT_RUN;
               // strap copied once; a software write in the window wins
               if (!sw_wrote_q && !wr_pll) begin
                  pll_ctrl_d[ccr_pkg::PLL_EN_BIT] = flt_d[IX_STRAP];
               end
            end
         end
         ccr_pkg::CCR_BOOT_RUN: begin
            boot_cnt_d = boot_cnt_q;
         end
         default: begin
            boot_d = ccr_pkg::CCR_BOOT_RUN;
         end
      endcase
   end

   // read port: one-cycle latency, unmapped addresses read zero
   always_comb begin
      rvalid_d = bus_rd;
      rdata_d  = rdata_q;
      if (bus_rd) begin
         case (bus_addr)
            ccr_pkg::ADDR_CLK_GATE: rdata_d = clk_gate_q;
            ccr_pkg::ADDR_PLL_CTRL: rdata_d = pll_ctrl_q;
            ccr_pkg::ADDR_SRC_DIV:  rdata_d = src_div_q;
            default:                rdata_d = '0;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         clk_gate_q <= ccr_pkg::RST_CLK_GATE;
         pll_ctrl_q <= RST_PLL_NOSTRAP;
         src_div_q  <= ccr_pkg::RST_SRC_DIV;
         rdata_q    <= '0;
         rvalid_q   <= 1'b0;
         boot_q     <= ccr_pkg::CCR_BOOT_SETTLE;
         boot_cnt_q <= '0;
         sw_wrote_q <= 1'b0;
      end else begin
         clk_gate_q <= clk_gate_d;
         pll_ctrl_q <= pll_ctrl_d;
         src_div_q  <= src_div_d;
         rdata_q    <= rdata_d;
         rvalid_q   <= rvalid_d;
         boot_q     <= boot_d;
         boot_cnt_q <= boot_cnt_d;
         sw_wrote_q <= sw_wrote_d;
      end
   end

   assign bus_rdata  = rdata_q;
   assign bus_rvalid = rvalid_q;

   // ------------------------------------------------------------------
   // pll macro controls, registered from the next register value so they track
   // the register with no extra lag
   logic                      pen_d, keep_d;
   logic [ccr_pkg::IDIV_W-1:0]  idiv_d;
   logic [ccr_pkg::FB_W-1:0]    fb_d;
   logic [ccr_pkg::ODIV_W-1:0]  odiv_d;
   logic                      pd_q, pd_d, byp_q, byp_d, sel_q;
   logic [ccr_pkg::IDIV_W-1:0]  idiv_q;
   logic [ccr_pkg::FB_W-1:0]    fb_q;
   logic [ccr_pkg::ODIV_W-1:0]  odiv_q;
   logic [ccr_pkg::IDIV_W:0]    in_ratio_q, in_ratio_d;
   logic [ccr_pkg::FB_W:0]      fb_ratio_q, fb_ratio_d;
   logic [7:0]                out_ratio_q, out_ratio_d;

   assign pen_d  = pll_ctrl_d[ccr_pkg::PLL_EN_BIT];
   assign keep_d = pll_ctrl_d[ccr_pkg::STOP_KEEP_BIT];
   assign idiv_d = pll_ctrl_d[ccr_pkg::IDIV_LSB +: ccr_pkg::IDIV_W];
   assign fb_d   = pll_ctrl_d[ccr_pkg::FB_LSB +: ccr_pkg::FB_W];
   assign odiv_d = pll_ctrl_d[ccr_pkg::ODIV_LSB +: ccr_pkg::ODIV_W];

   // divider rewrite while running: the macro needs a power-down pulse
   assign cif.div_change = wr_pll && pll_ctrl_q[ccr_pkg::PLL_EN_BIT] &&
      ((wval[ccr_pkg::IDIV_LSB +: ccr_pkg::IDIV_W] != idiv_q) ||
       (wval[ccr_pkg::FB_LSB +: ccr_pkg::FB_W] != fb_q) ||
       (wval[ccr_pkg::ODIV_LSB +: ccr_pkg::ODIV_W] != odiv_q));

   always_comb begin
      // in stop mode the stop-keep bit decides; otherwise the enable does
      if (stop_mode) begin
         pd_d = !keep_d;
      end else begin
         pd_d = !pen_d;
      end
      pd_d        = pd_d || cif.pd_hold;
      byp_d       = !pen_d;
      in_ratio_d  = {1'b0, idiv_d} + (ccr_pkg::IDIV_W + 1)'(1);
      fb_ratio_d  = {1'b0, fb_d} + (ccr_pkg::FB_W + 1)'(1);
      out_ratio_d = ccr_pow2({1'b0, odiv_d});
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pd_q        <= 1'b1;
         byp_q       <= 1'b1;
         sel_q       <= 1'b0;
         idiv_q      <= RST_PLL_NOSTRAP[ccr_pkg::IDIV_LSB +: ccr_pkg::IDIV_W];
         fb_q        <= RST_PLL_NOSTRAP[ccr_pkg::FB_LSB +: ccr_pkg::FB_W];
         odiv_q      <= RST_PLL_NOSTRAP[ccr_pkg::ODIV_LSB +: ccr_pkg::ODIV_W];
         in_ratio_q  <= '0;
         fb_ratio_q  <= '0;
         out_ratio_q <= '0;
      end else begin
         pd_q        <= pd_d;
         byp_q       <= byp_d;
         sel_q       <= pen_d;
         idiv_q      <= idiv_d;
         fb_q        <= fb_d;
         odiv_q      <= odiv_d;
         in_ratio_q  <= in_ratio_d;
         fb_ratio_q  <= fb_ratio_d;
         out_ratio_q <= out_ratio_d;
      end
   end

   // the macro forms fout = fin * feedback / (input * output) from these codes
   assign input_divide_ratio_code = idiv_q;
   assign feedback_ratio_code     = fb_q;
   assign output_div_sel          = odiv_q;
   assign pll_powerdown           = pd_q;
   assign pll_bypass              = byp_q;
   assign clk_src_pll             = sel_q;
   assign input_divide_ratio      = in_ratio_q;
   assign feedback_ratio          = fb_ratio_q;
   assign output_div_ratio        = out_ratio_q;

   // ------------------------------------------------------------------
   // low-power divider: a new code is adopted only on a system tick, so the
   // current period always completes; the pll controls are untouched
   logic [7:0]                  lp_cnt_q, lp_cnt_d;
   logic [ccr_pkg::LPDIV_W-1:0] lp_sel_q, lp_sel_d, lp_code;
   logic                        lp_en_q, lp_en_d;

   assign lp_code = pll_ctrl_q[ccr_pkg::LPDIV_LSB +: ccr_pkg::LPDIV_W];

   always_comb begin
      lp_sel_d = lp_sel_q;
      lp_en_d  = 1'b0;
      lp_cnt_d = lp_cnt_q - 8'h01;
      if (lp_cnt_q == 8'h00) begin
         lp_en_d  = 1'b1;
         lp_sel_d = lp_code;
         lp_cnt_d = ccr_pow2(lp_code) - 8'h01;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         lp_cnt_q <= '0;
         lp_sel_q <= '0;
         lp_en_q  <= 1'b0;
      end else begin
         lp_cnt_q <= lp_cnt_d;
         lp_sel_q <= lp_sel_d;
         lp_en_q  <= lp_en_d;
      end
   end

   assign lowpower_div_sel = lp_sel_q;
   assign sys_clk_en       = lp_en_q;

   // ------------------------------------------------------------------
   // shared lock / gpio pin
   logic pin_o_q, pin_o_d, pin_oe_q, pin_oe_d, gpio_in_q;

   always_comb begin
      if (pll_ctrl_q[ccr_pkg::LOCK_SEL_BIT]) begin
         pin_o_d  = flt_q[IX_LOCK];
         pin_oe_d = 1'b1;
      end else begin
         pin_o_d  = gpio_g_bit0_o;
         pin_oe_d = gpio_g_bit0_oe;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_o_q   <= 1'b0;
         pin_oe_q  <= 1'b0;
         gpio_in_q <= 1'b0;
      end else begin
         pin_o_q   <= pin_o_d;
         pin_oe_q  <= pin_oe_d;
         gpio_in_q <= flt_q[IX_PIN];
      end
   end

   assign lock_pin_o    = pin_o_q;
   assign lock_pin_oe   = pin_oe_q;
   assign gpio_g_bit0_i = gpio_in_q;

   // ------------------------------------------------------------------
   // rate converter clock gate and divider
   assign cif.src_on     = clk_gate_q[ccr_pkg::CG_ON_BIT];
   assign cif.src_factor = src_div_q[ccr_pkg::SRC_DIV_LSB +: ccr_pkg::SRC_DIV_W];
   assign src_clock_on   = clk_gate_q[ccr_pkg::CG_ON_BIT];
   assign src_div_factor = src_div_q[ccr_pkg::SRC_DIV_LSB +: ccr_pkg::SRC_DIV_W];
   assign src_clk_en     = cif.src_en;

   ccr_pd_hold #(
      .HOLD_CYC (ccr_pkg::PD_HOLD_CYC)
   ) u_pd_hold (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .cif      (cif.hold)
   );

   ccr_src_div #(
      .DIV_W (ccr_pkg::SRC_DIV_W)
   ) u_src_div (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .cif      (cif.srcdiv)
   );

endmodule

// ---- core/ccr_pkg.sv ----
// constants, register map and types of the clock control register block
package ccr_pkg;

   // bus geometry
   localparam int ADDR_W = 24;
   localparam int DATA_W = 24;

   // register addresses in data space (word addressed)
   localparam logic [ADDR_W-1:0] ADDR_CLK_GATE = 24'hffff7c;
   localparam logic [ADDR_W-1:0] ADDR_PLL_CTRL = 24'hffff7d;
   localparam logic [ADDR_W-1:0] ADDR_SRC_DIV  = 24'hffff7e;

   // reset values
   localparam logic [DATA_W-1:0] RST_CLK_GATE = 24'h000001;
   localparam logic [DATA_W-1:0] RST_PLL_CTRL = 24'h2b60c2;
   localparam logic [DATA_W-1:0] RST_SRC_DIV  = 24'h000022;

   // writable bits; reserved bits drop on write and read as zero
   localparam logic [DATA_W-1:0] WMASK_CLK_GATE = 24'h000001;
   localparam logic [DATA_W-1:0] WMASK_PLL_CTRL = 24'h3ff7ff;
   localparam logic [DATA_W-1:0] WMASK_SRC_DIV  = 24'h00007f;
   localparam logic [DATA_W-1:0] MASK_PLL_EN    = 24'h002000;

   // clock gate fields
   localparam int CG_ON_BIT = 0;

   // pll control fields
   localparam int LOCK_SEL_BIT  = 21;
   localparam int IDIV_LSB      = 16;
   localparam int IDIV_W        = 5;
   localparam int ODIV_LSB      = 14;
   localparam int ODIV_W        = 2;
   localparam int PLL_EN_BIT    = 13;
   localparam int STOP_KEEP_BIT = 12;
   localparam int LPDIV_LSB     = 8;
   localparam int LPDIV_W       = 3;
   localparam int FB_LSB        = 0;
   localparam int FB_W          = 8;

   // converter divider field
   localparam int SRC_DIV_LSB = 0;
   localparam int SRC_DIV_W   = 7;

   // timing
   localparam int CLK_PERIOD_PS = 4000;
   localparam int PD_HOLD_NS    = 50;
   // strictly more than the hold time, hence the extra cycle
   localparam int PD_HOLD_CYC   = (PD_HOLD_NS * 1000) / CLK_PERIOD_PS + 1;
   // edges after reset release until the filtered strap is valid
   localparam int STRAP_SETTLE_CYC = 4;
   localparam int SYNC_STAGES      = 3;

   typedef enum logic [1:0] {
      CCR_BOOT_SETTLE = 2'b00,
      CCR_BOOT_RUN    = 2'b01
   } ccr_boot_t;

   typedef enum logic {
      CCR_PD_IDLE = 1'b0,
      CCR_PD_HOLD = 1'b1
   } ccr_pd_t;

endpackage

// ---- core/ccr_clk_if.sv ----
// carrier between the register block and its power-down hold and converter divider
`timescale 1ns/100ps
interface ccr_clk_if;
   logic                           div_change;
   logic                           pd_hold;
   logic                           src_on;
   logic [ccr_pkg::SRC_DIV_W-1:0]  src_factor;
   logic                           src_en;

   modport ctrl (
      output div_change,
      output src_on,
      output src_factor,
      input  pd_hold,
      input  src_en
   );
   modport hold (
      input  div_change,
      output pd_hold
   );
   modport srcdiv (
      input  src_on,
      input  src_factor,
      output src_en
   );
endinterface

// ---- core/ccr_pd_hold.sv ----
// keeps the pll powered down for a fixed time after a divider change
`timescale 1ns/100ps
module ccr_pd_hold #(
   parameter int HOLD_CYC = ccr_pkg::PD_HOLD_CYC
) (
   // clock and reset
   input  wire logic  core_clk,
   input  wire logic  rst_n,
   // control carrier
   ccr_clk_if.hold    cif
);
   localparam int CW = $clog2(HOLD_CYC + 1);
   localparam logic [CW-1:0] LOAD = CW'(HOLD_CYC - 1);

   ccr_pkg::ccr_pd_t  st_q, st_d;
   logic [CW-1:0]     cnt_q, cnt_d;

   always_comb begin
      st_d  = st_q;
      cnt_d = cnt_q;
      // a fresh change restarts the full hold, even mid-hold
      if (cif.div_change) begin
         st_d  = ccr_pkg::CCR_PD_HOLD;
         cnt_d = LOAD;
      end else begin
         case (st_q)
            ccr_pkg::CCR_PD_IDLE: begin
               cnt_d = '0;
            end
            ccr_pkg::CCR_PD_HOLD: begin
               if (cnt_q == '0) begin
                  st_d = ccr_pkg::CCR_PD_IDLE;
               end else begin
                  cnt_d = cnt_q - CW'(1);
               end
            end
            default: begin
               st_d  = ccr_pkg::CCR_PD_IDLE;
               cnt_d = '0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q  <= ccr_pkg::CCR_PD_IDLE;
         cnt_q <= '0;
      end else begin
         st_q  <= st_d;
         cnt_q <= cnt_d;
      end
   end

   assign cif.pd_hold = (st_q == ccr_pkg::CCR_PD_HOLD);
endmodule

// ---- core/ccr_src_div.sv ----
// divided enable for the sample rate converter, gated by the clock gate bit
`timescale 1ns/100ps
module ccr_src_div #(
   parameter int DIV_W = ccr_pkg::SRC_DIV_W
) (
   // clock and reset
   input  wire logic  core_clk,
   input  wire logic  rst_n,
   // control carrier
   ccr_clk_if.srcdiv  cif
);
   logic [DIV_W-1:0] cnt_q, cnt_d;
   logic             en_q, en_d;

   always_comb begin
      cnt_d = cnt_q;
      en_d  = 1'b0;
      if (!cif.src_on) begin
         // parked at zero so the first pulse comes right after switch-on
         cnt_d = '0;
      end else if (cnt_q == '0) begin
         en_d  = 1'b1;
         cnt_d = cif.src_factor;
      end else begin
         cnt_d = cnt_q - DIV_W'(1);
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= '0;
         en_q  <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         en_q  <= en_d;
      end
   end

   assign cif.src_en = en_q;
endmodule

// ---- testbench/ccr_pll_model.sv ----
// behavioural analog pll macro: reports lock a fixed time after power-up
`timescale 1ns/100ps
module ccr_pll_model #(
   parameter int LOCK_CYC = 8
) (
   input  wire logic core_clk,
   input  wire logic pll_powerdown,
   input  wire logic pll_bypass,
   output wire logic lock_indicator
);
   int cnt_q = 0;
   // bypass and power-down both stop the oscillator, so lock is lost
   always_ff @(posedge core_clk) begin
      if (pll_powerdown || pll_bypass) cnt_q <= 0;
      else if (cnt_q < LOCK_CYC) cnt_q <= cnt_q + 1;
   end
   assign lock_indicator = (cnt_q == LOCK_CYC);
endmodule

// ---- testbench/ccr_top_props.sv ----
// concurrent checks on the ports of the clock control block
`timescale 1ns/100ps
module ccr_top_props (
   // clock and reset
   input logic core_clk, rst_n,
   // register port
   input logic [23:0] bus_addr, bus_rdata,
   input logic bus_rd, bus_rvalid, stop_mode,
   // pll codes and ratios
   input logic [4:0] input_divide_ratio_code,
   input logic [7:0] feedback_ratio_code, output_div_ratio,
   input logic [1:0] output_div_sel,
   input logic [5:0] input_divide_ratio,
   input logic [8:0] feedback_ratio,
   // clock selection and converter
   input logic pll_powerdown, pll_bypass, clk_src_pll, src_clock_on, src_clk_en
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   read_answer_a: assert property ($past(rst_n) |-> bus_rvalid == $past(bus_rd))
      else $error("read answer not one cycle after read");
   unmapped_zero_a: assert property (bus_rd && bus_addr[23:8] != 16'hffff |=> bus_rdata == 24'h0)
      else $error("unmapped read not zero");
   idiv_ratio_a: assert property ($past(rst_n) |-> input_divide_ratio == {1'b0, input_divide_ratio_code} + 6'h1)
      else $error("input ratio wrong");
   fb_ratio_a: assert property ($past(rst_n) |-> feedback_ratio == {1'b0, feedback_ratio_code} + 9'h1)
      else $error("feedback ratio wrong");
   odiv_ratio_a: assert property ($past(rst_n) |-> output_div_ratio == 8'h1 << output_div_sel)
      else $error("output ratio wrong");
   bypass_sel_a: assert property (pll_bypass == !clk_src_pll)
      else $error("bypass and clock source disagree");
   disabled_off_a: assert property (!stop_mode && !$past(stop_mode) && !clk_src_pll |-> pll_powerdown)
      else $error("disabled pll not powered down");
   pd_hold_a: assert property ($rose(pll_powerdown) && clk_src_pll && !stop_mode |-> pll_powerdown [*8])
      else $error("power-down hold too short");
   gate_quiet_a: assert property (!src_clock_on ##1 !src_clock_on |-> !src_clk_en)
      else $error("converter enable while gated off");
   cover property (bus_rd ##1 bus_rvalid);
   cover property ($rose(pll_powerdown) && clk_src_pll);
   cover property ($fell(pll_bypass));
endmodule
bind ccr_top ccr_top_props props_u (.*);

// ---- testbench/test_pll_clock_control_regs.sv ----
// self-checking bench of the clock control registers against a register model
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin error_cnt++; \
   $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module test_pll_clock_control_regs;
   logic core_clk, rst_n, bus_wr, bus_rd, bus_rvalid, pll_boot_strap, stop_mode;
   logic lock_indicator, lock_pin_o, lock_pin_oe, gpio_g_bit0_o, gpio_g_bit0_oe;
   logic gpio_g_bit0_i, pll_powerdown, pll_bypass, clk_src_pll, sys_clk_en;
   logic src_clock_on, src_clk_en;
   logic [23:0] bus_addr, bus_wdata, bus_rdata, d;
   logic [4:0]  input_divide_ratio_code;
   logic [7:0]  feedback_ratio_code, output_div_ratio;
   logic [1:0]  output_div_sel;
   logic [5:0]  input_divide_ratio;
   logic [8:0]  feedback_ratio;
   logic [2:0]  lowpower_div_sel;
   logic [6:0]  src_div_factor;
   int          error_cnt = 0, compares = 0, k, n;
   int unsigned x = 36;
   int          m[3] = '{'h1, 'h2b60c2, 'h22};
   int          msk[3] = '{'h1, 'h3ff7ff, 'h7f};
   // released pin is pulled up
   wire         lock_pin_i = lock_pin_oe ? lock_pin_o : 1'b1;
   ccr_top dut_u (.*);
   ccr_pll_model pll_u (.core_clk, .pll_powerdown, .pll_bypass, .lock_indicator);
   function automatic int unsigned rnd();
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   task wr(input logic [23:0] a, input logic [23:0] v);
      bus_addr = a;
      bus_wdata = v;
      bus_wr = 1'b1;
      @(negedge core_clk) bus_wr = 1'b0;
      // idle cycle so a following call never re-raises the strobe in this step
      @(negedge core_clk);
   endtask
   task rd(input logic [23:0] a, input int e);
      bus_addr = a;
      bus_rd = 1'b1;
      @(negedge core_clk) bus_rd = 1'b0;
      `CHK(bus_rvalid, 1'b1)
      `CHK(bus_rdata, 24'(e))
      @(negedge core_clk);
   endtask
   task wrap_up;
      if (error_cnt == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   initial begin
      {rst_n, bus_wr, bus_rd, stop_mode, gpio_g_bit0_o, gpio_g_bit0_oe} = '0;
      {bus_addr, bus_wdata} = '0;
      pll_boot_strap = 1'b1;
      repeat (5) @(posedge core_clk);
      @(negedge core_clk) rst_n = 1'b1;
      repeat (6) @(negedge core_clk);
      for (int i = 0; i < 3; i++) rd(ccr_pkg::ADDR_CLK_GATE + 24'(i), m[i]);
      wr(24'h000010, 24'hffffff);
      rd(24'h000010, 0);
      // legal codes; frequency lowered through the low-power code only
      wr(ccr_pkg::ADDR_PLL_CTRL, 24'h2b61c2);
      m[1] = 'h2b61c2;
      n = 0;
      repeat (140) @(negedge core_clk) n += pll_powerdown;
      `CHK(n, 0)
      `CHK(lowpower_div_sel, 3'h1)
      for (int i = 0; i < 40; i++) begin
         k = rnd() % 3;
         // reserved pll control bits are left clear, as software must
         d = 24'(rnd()) & ((k == 1) ? 24'h3ff7ff : 24'hffffff);
         m[k] = d & msk[k];
         stop_mode = 1'(rnd() % 2);
         {gpio_g_bit0_o, gpio_g_bit0_oe} = 2'(rnd());
         wr(ccr_pkg::ADDR_CLK_GATE + 24'(k), d);
         // covers power-down hold, lock time, pin filters and the slowest low-power tick
         repeat (140) @(negedge core_clk);
         rd(ccr_pkg::ADDR_CLK_GATE + 24'(k), m[k]);
         `CHK(input_divide_ratio, 6'((m[1] >> 16 & 31) + 1))
         `CHK(feedback_ratio, 9'((m[1] & 255) + 1))
         `CHK(output_div_ratio, 8'(1 << (m[1] >> 14 & 3)))
         `CHK(lowpower_div_sel, 3'(m[1] >> 8))
         `CHK(clk_src_pll, m[1][13])
         `CHK(pll_powerdown, 1'(stop_mode ? ~m[1] >> 12 : ~m[1] >> 13))
         `CHK(src_clock_on, m[0][0])
         `CHK(src_div_factor, 7'(m[2]))
         `CHK(gpio_g_bit0_i, lock_pin_i)
         if (m[1][21]) `CHK({lock_pin_o, lock_pin_oe}, {lock_indicator, 1'b1})
         else `CHK({lock_pin_o, lock_pin_oe}, {gpio_g_bit0_o, gpio_g_bit0_oe})
         `CHK(pll_bypass, !m[1][13])
         d = 24'(m[1]);
         `CHK({input_divide_ratio_code, output_div_sel}, {d[20:16], d[15:14]})
         `CHK(feedback_ratio_code, d[7:0])
         n = 0;
         repeat (128) @(negedge core_clk) n += sys_clk_en;
         `CHK(n, 128 >> (m[1] >> 8 & 7))
      end
      // second reset with the strap low: enable must come up clear
      {stop_mode, pll_boot_strap, rst_n} = '0;
      repeat (5) @(negedge core_clk);
      rst_n = 1'b1;
      m = '{'h1, 'h2b40c2, 'h22};
      repeat (6) @(negedge core_clk);
      for (int i = 0; i < 3; i++) rd(ccr_pkg::ADDR_CLK_GATE + 24'(i), m[i]);
      `CHK(pll_powerdown, 1'b1)
      wrap_up();
   end
endmodule
